// ### hdl/eep_pkg.sv
// package for the two-wire memory target front end: constants and types
package eep_pkg;

    // system clock and write cycle timing
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int WRITE_TIME_US = 5000;
    // longest time: integer division rounds down
    localparam int WRITE_CYCLES =
        (SYS_CLK_HZ / 1_000_000) * WRITE_TIME_US;

    // select byte layout, most significant bit first on the wire
    localparam int SEL_RW_BIT = 0;
    localparam int SEL_CS_LSB = 1;
    localparam int SEL_CS_MSB = 3;
    localparam int SEL_ID_LSB = 4;
    localparam int SEL_ID_MSB = 7;
    localparam logic SEL_RW_READ = 1'h1;

    // device type code; value is arbitrary
    localparam logic [3:0] DEV_TYPE_ID_DEF = 4'h5;

    // bits in one byte before the acknowledge slot
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;

    // toggle index of each bus event crossing from the sampling domain
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_RISE = 2;
    localparam int EV_FALL = 3;
    localparam int EV_NUM = 4;

    // events from the sampling domain: one toggle each plus sampled bit
    typedef struct packed {
        logic [EV_NUM-1:0] tg;
        logic bit_val;
    } eep_ev_t;

    // write request handed to the array engine
    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } eep_wr_t;

    // protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SEL,
        ST_SEL_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_WAIT_STOP,
        ST_BUSY
    } eep_state_t;

endpackage

// ### hdl/eep_link.sv
// bus line sampler on the fast sampling clock: start, stop and edge events
`timescale 1ns/1ps
module eep_link import eep_pkg::*; (
    input wire logic scl_smp_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output eep_ev_t ev_o
);

    typedef struct packed {
        logic rst1;
        logic rst2;
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        eep_ev_t ev;
    } eep_link_t;

    eep_link_t s_r;
    eep_link_t s_nxt;

    // lines pass two flops; the third stage is only for edge detection
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst1 = rst_i;
        s_nxt.rst2 = s_r.rst1;
        s_nxt.scl1 = scl_i;
        s_nxt.scl2 = s_r.scl1;
        s_nxt.scl3 = s_r.scl2;
        s_nxt.sda1 = sda_i;
        s_nxt.sda2 = s_r.sda1;
        s_nxt.sda3 = s_r.sda2;
        if (s_r.rst2) begin
            s_nxt.ev = '0;
        end else begin
            // data falls with clock high
            if (s_r.scl2 && s_r.scl3 && s_r.sda3 && !s_r.sda2) begin
                s_nxt.ev.tg[EV_START] = ~s_r.ev.tg[EV_START];
            end
            // data rises with clock high
            if (s_r.scl2 && s_r.scl3 && !s_r.sda3 && s_r.sda2) begin
                s_nxt.ev.tg[EV_STOP] = ~s_r.ev.tg[EV_STOP];
            end
            // bit value is held until the next rise, long past the crossing
            if (s_r.scl2 && !s_r.scl3) begin
                s_nxt.ev.tg[EV_RISE] = ~s_r.ev.tg[EV_RISE];
                s_nxt.ev.bit_val = s_r.sda2;
            end
            if (!s_r.scl2 && s_r.scl3) begin
                s_nxt.ev.tg[EV_FALL] = ~s_r.ev.tg[EV_FALL];
            end
        end
    end

    always_ff @(posedge scl_smp_clk_i) begin
        s_r <= s_nxt;
    end

    assign ev_o = s_r.ev;

    start_toggle_a: assert property (
        @(posedge scl_smp_clk_i) disable iff (s_r.rst2)
        (s_r.scl2 && s_r.scl3 && s_r.sda3 && !s_r.sda2)
        |=> (s_r.ev.tg[EV_START] != $past(s_r.ev.tg[EV_START])))
        else $error("start not flagged on data fall with clock high");

endmodule // eep_link

// ### hdl/eep_front.sv
// two-wire memory target front end: framing, select decode, acknowledge
`timescale 1ns/1ps
module eep_front import eep_pkg::*; #(
    parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE_ID = DEV_TYPE_ID_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_smp_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic chip_sel_pin_hi_i,
    input wire logic chip_sel_pin_mid_i,
    input wire logic chip_sel_pin_lo_i,
    input wire logic write_guard_in_i,
    input wire logic [7:0] rd_byte_i,
    output logic rd_req_o,
    output eep_wr_t wr_req_o,
    output logic busy_o,
    output logic standby_o
);

    localparam int BW = $clog2(WRITE_CYCLES_P + 1);
    localparam logic [BW-1:0] BUSY_LOAD = BW'(WRITE_CYCLES_P);
    localparam logic [BW-1:0] BUSY_ONE = BW'(1);

    typedef struct packed {
        logic [EV_NUM-1:0] tg1;
        logic [EV_NUM-1:0] tg2;
        logic [EV_NUM-1:0] tg3;
        logic [3:0] pin1;
        logic [3:0] pin2;
        eep_state_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic sda_drv;
        logic rw;
        logic mack;
        logic tenth;
        logic [BW-1:0] busy_cnt;
        logic rd_req;
        eep_wr_t wr;
    } eep_main_t;

    eep_main_t s_r;
    eep_main_t s_nxt;
    eep_ev_t link_ev;
    logic [EV_NUM-1:0] ev;
    logic guard;
    logic [2:0] cs_pins;

    // select code check: type identifier and chip-select field
    function automatic logic sel_match(input logic [7:0] b,
                                       input logic [2:0] cs,
                                       input logic [3:0] id);
        return (b[SEL_ID_MSB:SEL_ID_LSB] == id) &&
               (b[SEL_CS_MSB:SEL_CS_LSB] == cs);
    endfunction

    // sampling runs on the fast clock so narrow bus pulses are not missed
    eep_link u_link (
        .scl_smp_clk_i(scl_smp_clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev_o(link_ev)
    );

    // one-cycle event pulses from the synchronised toggles
    assign ev = s_r.tg2 ^ s_r.tg3;
    // pins passed two flops; open pins rely on board pull-downs
    assign guard = s_r.pin2[3];
    assign cs_pins = s_r.pin2[2:0];

    // protocol engine; start and stop take priority over clock edges
    always_comb begin
        s_nxt = s_r;
        s_nxt.tg1 = link_ev.tg;
        s_nxt.tg2 = s_r.tg1;
        s_nxt.tg3 = s_r.tg2;
        s_nxt.pin1 = {write_guard_in_i, chip_sel_pin_hi_i,
                      chip_sel_pin_mid_i, chip_sel_pin_lo_i};
        s_nxt.pin2 = s_r.pin1;
        s_nxt.rd_req = 1'b0;
        s_nxt.wr.stb = 1'b0;
        if (s_r.st == ST_BUSY) begin
            // bus ignored entirely, output released
            s_nxt.sda_drv = 1'b0;
            s_nxt.busy_cnt = s_r.busy_cnt - BUSY_ONE;
            if (s_r.busy_cnt == BUSY_ONE) begin
                s_nxt.st = ST_IDLE;
            end
        end else if (ev[EV_START]) begin
            // also a repeated start in the middle of a transfer
            s_nxt.st = ST_SEL;
            s_nxt.cnt = 4'h0;
            s_nxt.sda_drv = 1'b0;
            s_nxt.tenth = 1'b0;
        end else if (ev[EV_STOP]) begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.tenth = 1'b0;
            if (s_r.tenth) begin
                s_nxt.st = ST_BUSY;
                s_nxt.busy_cnt = BUSY_LOAD;
            end else begin
                s_nxt.st = ST_IDLE;
            end
        end else if (ev[EV_RISE]) begin
            case (s_r.st)
                ST_SEL, ST_ADDR, ST_WDATA: begin
                    if (s_r.cnt < BYTE_BITS) begin
                        // msb arrives first
                        s_nxt.shreg = {s_r.shreg[6:0], link_ev.bit_val};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                ST_RACK: begin
                    // master pulls low to ask for another byte
                    s_nxt.mack = !link_ev.bit_val;
                end
                default: begin
                end
            endcase
        end else if (ev[EV_FALL]) begin
            // any further clock after the tenth slot cancels the launch
            s_nxt.tenth = 1'b0;
            case (s_r.st)
                ST_SEL: begin
                    if (s_r.cnt == BYTE_BITS) begin
                        if (sel_match(s_r.shreg, cs_pins, DEV_TYPE_ID)) begin
                            s_nxt.st = ST_SEL_ACK;
                            s_nxt.sda_drv = 1'b1;
                            s_nxt.rw = (s_r.shreg[SEL_RW_BIT] ==
                                        SEL_RW_READ);
                        end else begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.sda_drv = 1'b0;
                        end
                    end
                end
                ST_SEL_ACK: begin
                    if (s_r.rw) begin
                        // first bit goes out right after the ack slot
                        s_nxt.st = ST_RDATA;
                        s_nxt.shreg = rd_byte_i;
                        s_nxt.rd_req = 1'b1;
                        s_nxt.sda_drv = !rd_byte_i[7];
                        s_nxt.cnt = 4'h1;
                    end else begin
                        s_nxt.st = ST_ADDR;
                        s_nxt.sda_drv = 1'b0;
                        s_nxt.cnt = 4'h0;
                    end
                end
                ST_ADDR: begin
                    if (s_r.cnt == BYTE_BITS) begin
                        s_nxt.st = ST_ADDR_ACK;
                        s_nxt.sda_drv = 1'b1;
                        s_nxt.wr.addr = s_r.shreg;
                    end
                end
                ST_ADDR_ACK, ST_WDATA_ACK: begin
                    s_nxt.st = ST_WDATA;
                    s_nxt.sda_drv = 1'b0;
                    s_nxt.cnt = 4'h0;
                    // only an acknowledged data byte arms the write
                    s_nxt.tenth = (s_r.st == ST_WDATA_ACK) &&
                                  s_r.sda_drv;
                end
                ST_WDATA: begin
                    if (s_r.cnt == BYTE_BITS) begin
                        s_nxt.st = ST_WDATA_ACK;
                        s_nxt.sda_drv = !guard;
                        if (!guard) begin
                            s_nxt.wr.data = s_r.shreg;
                            s_nxt.wr.stb = 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (s_r.cnt == BYTE_BITS) begin
                        // release so the master can answer
                        s_nxt.st = ST_RACK;
                        s_nxt.sda_drv = 1'b0;
                        s_nxt.mack = 1'b0;
                    end else begin
                        s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                        s_nxt.sda_drv = !s_r.shreg[6];
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (s_r.mack) begin
                        s_nxt.st = ST_RDATA;
                        s_nxt.shreg = rd_byte_i;
                        s_nxt.rd_req = 1'b1;
                        s_nxt.sda_drv = !rd_byte_i[7];
                        s_nxt.cnt = 4'h1;
                    end else begin
                        // no ack: off the bus until stop
                        s_nxt.st = ST_WAIT_STOP;
                        s_nxt.sda_drv = 1'b0;
                    end
                end
                default: begin
                    s_nxt.sda_drv = 1'b0;
                end
            endcase
        end
    end

    // reset clears everything; bus ignored while held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !s_r.sda_drv;
    assign rd_req_o = s_r.rd_req;
    assign wr_req_o = s_r.wr;
    assign busy_o = (s_r.st == ST_BUSY);
    assign standby_o = (s_r.st == ST_IDLE);

    // checks
    reset_idle_a: assert property (
        @(posedge clk_i) rst_i |=> (s_r.st == ST_IDLE) && !s_r.sda_drv)
        else $error("reset did not return to standby");

    start_seen_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ev[EV_START] && s_r.st != ST_BUSY) |=> (s_r.st == ST_SEL)
            && (s_r.cnt == 4'h0))
        else $error("start did not open select phase");

    stop_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && ev[EV_STOP] && s_r.st != ST_BUSY && !s_r.tenth)
        |=> (s_r.st == ST_IDLE))
        else $error("stop did not return to standby");

    write_launch_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && ev[EV_STOP] && s_r.st != ST_BUSY && s_r.tenth)
        |=> (s_r.st == ST_BUSY) && (s_r.busy_cnt == BUSY_LOAD))
        else $error("write cycle not launched by stop after data ack");

    busy_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ST_BUSY && s_r.busy_cnt > BUSY_ONE)
        |=> (s_r.st == ST_BUSY) && (s_r.busy_cnt ==
            $past(s_r.busy_cnt) - BUSY_ONE))
        else $error("write cycle left early or start accepted while busy");

    busy_quiet_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ST_BUSY) |-> sda_oe_n_o && !s_r.rd_req)
        else $error("data line driven during write cycle");

    busy_bound_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == ST_BUSY) |-> (s_r.busy_cnt <= BUSY_LOAD)
            && (s_r.busy_cnt != '0))
        else $error("write cycle counter out of range");

    sel_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && ev[EV_FALL] && s_r.st == ST_SEL
         && s_r.cnt == BYTE_BITS && sel_match(s_r.shreg, cs_pins,
         DEV_TYPE_ID)) |=> (s_r.st == ST_SEL_ACK) && !sda_oe_n_o)
        else $error("matching select code not acknowledged");

    sel_miss_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && ev[EV_FALL] && s_r.st == ST_SEL
         && s_r.cnt == BYTE_BITS && !sel_match(s_r.shreg, cs_pins,
         DEV_TYPE_ID)) |=> (s_r.st == ST_IDLE) && sda_oe_n_o)
        else $error("mismatching select code not ignored");

    guard_withheld_acknowledge_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && ev[EV_FALL]
         && s_r.st == ST_WDATA && s_r.cnt == BYTE_BITS && guard)
        |=> sda_oe_n_o && !s_r.wr.stb ##1 !s_r.wr.stb)
        else $error("data byte acknowledged with write guard high");

    rise_capture_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && ev[EV_RISE]
         && s_r.st == ST_SEL && s_r.cnt < BYTE_BITS)
        |=> (s_r.shreg[0] == $past(link_ev.bit_val))
            && (s_r.cnt == $past(s_r.cnt) + 4'h1))
        else $error("bit not captured on clock rise");

    open_drain_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sda_o == 1'b0)
        else $error("data line driven high");

    // unguarded data byte must be acked and handed on
    guard_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && !ev[EV_RISE] && ev[EV_FALL]
         && s_r.st == ST_WDATA && s_r.cnt == BYTE_BITS && !guard)
        |=> !sda_oe_n_o && s_r.wr.stb)
        else $error("data byte not acknowledged with write guard low");

    // master declined more data: let go of the line, no further load
    read_nack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ev[EV_START] && !ev[EV_STOP] && !ev[EV_RISE] && ev[EV_FALL]
         && s_r.st == ST_RACK && !s_r.mack)
        |=> (s_r.st == ST_WAIT_STOP) && sda_oe_n_o && !s_r.rd_req)
        else $error("bus kept after an unacknowledged read byte");

endmodule // eep_front

// ### bench/eep_master.sv
// two-wire bus master model: drives the serial clock, shares the data line
`timescale 1ns/1ps
module eep_master import eep_pkg::*; #(
    parameter int QTR = 12
) (
    input wire logic clk_i,
    input wire logic dev_oe_n_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull_r;

    // wired-and with pull-up: a released line reads high, never stale
    assign sda_o = ~pull_r & dev_oe_n_i;

    // idle bus: clock stands high, data released
    initial begin
        scl_o = 1'h1;
        pull_r = 1'h0;
    end

    // all changes land just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one bit slot; data moves only while the clock is low
    task automatic bit_slot(input logic v, output logic r);
        pull_r = ~v;
        tick(QTR);
        scl_o = 1'h1;
        tick(QTR);
        r = sda_o;
        tick(QTR);
        scl_o = 1'h0;
        tick(QTR);
    endtask

    // start also serves as repeated start from a low clock
    task automatic start();
        pull_r = 1'h0;
        tick(QTR);
        scl_o = 1'h1;
        tick(QTR);
        pull_r = 1'h1;
        tick(QTR);
        scl_o = 1'h0;
        tick(QTR);
    endtask

    // only called with the clock low, so no false start
    task automatic stop();
        pull_r = 1'h1;
        tick(QTR);
        scl_o = 1'h1;
        tick(QTR);
        pull_r = 1'h0;
        tick(QTR);
    endtask

    // byte out msb first, line released in the ninth slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'h1, r);
        ack = ~r;
    endtask

    // byte in, then our own ack (0) or no-ack (1)
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'h1, r);
            b[i] = r;
        end
        bit_slot(nack, r);
    endtask
endmodule // eep_master

// ### bench/testbench.sv
// self-checking bench for the two-wire memory target front end
`timescale 1ns/1ps
module testbench import eep_pkg::*; ();
    localparam int WP = 1500;
    localparam logic [3:0] TYPE_ID = 4'h9; // arbitrary type code
    logic clk, lclk, rst, scl, sda, oe_n, sda_d, guard, rd_req, busy;
    logic standby;
    logic [2:0] cs;
    logic [7:0] rd_byte;
    eep_wr_t wr_req;
    int n_mismatch = 0;
    int comparisons = 0;
    int busy_cnt = 0;
    logic [15:0] wq[$];
    logic [7:0] rq[$];

    // short write time keeps polling inside the busy window
    eep_front #(.WRITE_CYCLES_P(WP), .DEV_TYPE_ID(TYPE_ID)) dut_u (
        .clk_i(clk), .rst_i(rst), .scl_smp_clk_i(lclk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_n_o(oe_n),
        .chip_sel_pin_hi_i(cs[2]), .chip_sel_pin_mid_i(cs[1]),
        .chip_sel_pin_lo_i(cs[0]), .write_guard_in_i(guard),
        .rd_byte_i(rd_byte), .rd_req_o(rd_req), .wr_req_o(wr_req),
        .busy_o(busy), .standby_o(standby));

    eep_master m_u (.clk_i(clk), .dev_oe_n_i(oe_n), .scl_o(scl),
        .sda_o(sda));

    // system clock, and a link clock of unrelated phase
    always #20 clk = ~clk;
    initial begin
        lclk = 1'h0;
        #1.3;
        forever #3 lclk = ~lclk;
    end

    task automatic fail(input string msg);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic cmp_bit(input logic got, input logic exp,
        input string msg);
        comparisons++;
        if (got !== exp) fail(msg);
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp,
        input string msg);
        comparisons++;
        if (got !== exp) fail(msg);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watcher: strobes take the oldest note; read bytes noted when taken
    always @(posedge clk) begin
        if (busy === 1'h1) busy_cnt++;
        if (oe_n === 1'h0) cmp_bit(sda_d, 1'h0, "pin driven high");
        if (wr_req.stb === 1'h1) begin
            if (wq.size() == 0) fail("unexpected write strobe");
            else cmp_val({wr_req.addr, wr_req.data}, wq.pop_front(),
                "write strobe");
        end
        if (rd_req === 1'h1) begin
            rq.push_back(rd_byte);
            #1 rd_byte = 8'($urandom);
        end
    end

    // select, address and n data bytes, no stop
    task automatic wr_seq(input int n, input logic dack);
        logic a;
        logic [7:0] ad, d;
        ad = 8'($urandom);
        m_u.start();
        m_u.send_byte({TYPE_ID, cs, 1'h0}, a);
        cmp_bit(a, 1'h1, "write select ack");
        m_u.send_byte(ad, a);
        cmp_bit(a, 1'h1, "address ack");
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (dack) wq.push_back({ad, d});
            m_u.send_byte(d, a);
            cmp_bit(a, dack, "data ack");
        end
    endtask

    // main sequence
    initial begin
        logic a;
        logic [7:0] b, sel;
        clk = 1'h0;
        rst = 1'h1;
        cs = 3'h0;
        guard = 1'h0;
        rd_byte = 8'h00;
        void'($urandom(25957));
        m_u.tick(12);
        rst = 1'h0;
        cmp_bit(standby, 1'h1, "standby after reset");
        cmp_bit(oe_n, 1'h1, "released after reset");
        end_test("reset");
        // odd passes miss on chip select, pass 6 on type code
        for (int i = 0; i < 8; i++) begin
            cs = (i == 0) ? 3'h0 : 3'($urandom);
            guard = 1'($urandom);
            sel = {TYPE_ID, cs, 1'h0};
            if (i[0]) sel[3:1] = cs ^ 3'($urandom_range(7, 1));
            if (i == 6) sel[7:4] = ~TYPE_ID;
            m_u.tick(12);
            m_u.start();
            m_u.send_byte(sel, a);
            cmp_bit(a, !i[0] && i != 6, "select");
            if (i[0] || i == 6)
                cmp_bit(standby, 1'h1, "standby on miss");
            m_u.stop();
        end
        end_test("select");
        guard = 1'h0;
        cs = 3'h0;
        m_u.tick(12);
        wr_seq(2, 1'h1);
        busy_cnt = 0;
        m_u.stop();
        for (int k = 0; k < 20 && busy !== 1'h1; k++) @(posedge clk);
        #1 cmp_bit(busy, 1'h1, "write cycle launched");
        m_u.start();
        m_u.send_byte({TYPE_ID, cs, 1'h0}, a);
        cmp_bit(a, 1'h0, "ack while busy");
        m_u.stop();
        for (int k = 0; k < 2 * WP && standby !== 1'h1; k++) @(posedge clk);
        #1 cmp_bit(busy_cnt <= WP && busy_cnt >= WP - 2, 1'h1,
            "write time");
        end_test("write");
        guard = 1'h1;
        cs = 3'($urandom);
        m_u.tick(12);
        wr_seq(1, 1'h0);
        m_u.stop();
        m_u.tick(40);
        cmp_bit(busy, 1'h0, "guarded write");
        guard = 1'h0;
        end_test("guard");
        // address only, then repeated start into a two-byte read
        m_u.tick(12);
        wr_seq(0, 1'h0);
        rd_byte = 8'($urandom);
        m_u.start();
        m_u.send_byte({TYPE_ID, cs, 1'h1}, a);
        cmp_bit(a, 1'h1, "read select ack");
        m_u.recv_byte(1'h0, b);
        cmp_val(16'(b), 16'(rq.pop_front()), "read byte");
        m_u.recv_byte(1'h1, b);
        cmp_val(16'(b), 16'(rq.pop_front()), "read byte");
        cmp_bit(oe_n, 1'h1, "released on no-ack");
        m_u.stop();
        m_u.tick(12);
        cmp_bit(standby, 1'h1, "standby after read");
        cmp_bit(busy, 1'h0, "no write after address");
        end_test("read");
        // reset inside a frame: rest of the frame is ignored
        m_u.start();
        m_u.send_byte({TYPE_ID, cs, 1'h0}, a);
        rst = 1'h1;
        m_u.tick(12);
        rst = 1'h0;
        m_u.tick(12);
        cmp_bit(standby, 1'h1, "standby after mid reset");
        m_u.send_byte(8'($urandom), a);
        cmp_bit(a, 1'h0, "ignored until start");
        m_u.stop();
        m_u.tick(12);
        wr_seq(0, 1'h0);
        m_u.stop();
        cmp_bit(busy, 1'h0, "no write on early stop");
        cmp_val(16'(wq.size() + rq.size()), 16'h0000, "left notes");
        end_test("mid reset");
        test_done();
    end

    // watchdog well beyond the expected run of under a millisecond
    initial begin
        #2_000_000;
        fail("watchdog expired");
        test_done();
    end
endmodule // testbench
